// ### inc/divider_plan_pkg.sv
// Constants shared by the divider plan calculator and the oscillator divider register end.
// Assumes one 125 MHz clock for both ends and frequencies carried as whole hertz.

package divider_plan_pkg;

    // Datapath widths
    localparam int DIV_W   = 72;
    localparam int DEN_W   = 34;
    localparam int CALC_W  = 48;
    localparam int TOTAL_W = 17;
    localparam int FRAC_W  = 32;
    localparam int INT_W   = 11;
    localparam int FB_W    = 43;
    localparam int EXP_W   = 3;
    localparam int TRIM_W  = 8;
    localparam logic [6:0] DIV_STEPS = 7'h48;

    // Oscillator window and reference, in hertz
    localparam logic [CALC_W-1:0] FVCO_MIN_HZ = 48'd10800000000;
    localparam logic [CALC_W-1:0] FVCO_MAX_HZ = 48'd13122200000;
    localparam logic [DEN_W-1:0]  FOSC_HZ     = 34'd152600000;

    // Fine and power-of-two divider limits
    localparam logic [INT_W-1:0] FINE_MAX      = 11'h7fe;
    localparam logic [INT_W-1:0] FINE_MIN      = 11'h005;
    localparam logic [INT_W-1:0] FINE_ODD_MAX  = 11'h021;
    localparam logic [EXP_W-1:0] POW2_EXP_MAX  = 3'h5;
    localparam logic [5:0]       POW2_RATIO_CAP = 6'h20;

    // Predivider thresholds on the integer part of the feedback ratio
    localparam logic [INT_W-1:0]  PRE_LIMIT_18 = 11'h048;
    localparam logic [INT_W-1:0]  PRE_LIMIT_20 = 11'h04f;
    localparam logic [INT_W-1:0]  PRE_LIMIT_22 = 11'h056;
    localparam logic [TRIM_W-1:0] PRE_16 = 8'h10;
    localparam logic [TRIM_W-1:0] PRE_18 = 8'h12;
    localparam logic [TRIM_W-1:0] PRE_20 = 8'h14;
    localparam logic [TRIM_W-1:0] PRE_22 = 8'h16;

    // Gain trim numerator: scale times nominal ADC rate times post divide
    localparam longint GAIN_SCALE  = 128;
    localparam longint ADC_RATE_HZ = 80000000;
    localparam longint ADC_POSTDIV = 8;
    localparam logic [40:0] GAIN_NUM = 41'(GAIN_SCALE * ADC_RATE_HZ * ADC_POSTDIV);

    // Controller register offsets (byte addresses, word aligned)
    localparam logic [7:0] REG_REQ_FREQ = 8'h00;
    localparam logic [7:0] REG_CONTROL  = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_DIVIDERS = 8'h0c;
    localparam logic [7:0] REG_FB_LOW   = 8'h10;
    localparam logic [7:0] REG_FB_HIGH  = 8'h14;
    localparam logic [7:0] REG_TRIM     = 8'h18;

    // Field positions
    localparam int CTRL_START_BIT  = 0;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_ERROR_BIT  = 2;
    localparam int DIVS_FINE_LSB   = 16;
    localparam int TRIM_PRE_LSB    = 8;

    typedef enum logic [3:0] {
        S_IDLE      = 4'h0,
        S_DIV_TOTAL = 4'h1,
        S_PICK      = 4'h2,
        S_CHECK     = 4'h3,
        S_DIV_FB    = 4'h4,
        S_PRE       = 4'h5,
        S_DIV_GAIN  = 4'h6,
        S_SEND      = 4'h7,
        S_ERROR     = 4'h8
    } plan_state_t;

endpackage

// ### inc/divider_plan_if.sv
// Link between the plan calculator and the oscillator divider register end.
// Both ends share one clock; load is a one-cycle strobe qualifying all fields.
`timescale 1ns/1ps
`default_nettype none

interface divider_plan_if;
    import divider_plan_pkg::*;

    logic                load;
    logic [EXP_W-1:0]    power_of_two_divider;
    logic [INT_W-1:0]    fine_output_divider;
    logic [FB_W-1:0]     feedback_ratio;
    logic [TRIM_W-1:0]   tuning_gain_trim;

    modport host (
        output load,
        output power_of_two_divider,
        output fine_output_divider,
        output feedback_ratio,
        output tuning_gain_trim
    );

    modport device (
        input load,
        input power_of_two_divider,
        input fine_output_divider,
        input feedback_ratio,
        input tuning_gain_trim
    );
endinterface

`default_nettype wire

// ### hw/oscillator_divider_regs.sv
// Oscillator end: holds the divider and gain trim settings written over the link.
// Assumes the calculator shares clk_i and that its fields are valid only with load high.
`timescale 1ns/1ps
`default_nettype none

module oscillator_divider_regs
    import divider_plan_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    divider_plan_if.device     link,
    output logic [EXP_W-1:0]   power_of_two_select_o,
    output logic [5:0]         power_of_two_ratio_o,
    output logic [INT_W-1:0]   fine_output_divider_o,
    output logic [INT_W-1:0]   feedback_ratio_integer_o,
    output logic [FRAC_W-1:0]  feedback_ratio_fraction_o,
    output logic [TRIM_W-1:0]  tuning_gain_trim_o,
    output logic               settings_loaded_o,
    output logic               settings_valid_o,
    output logic               setting_error_o
);

    logic fine_bad;

    // Acceptance check on the incoming fine ratio; only ratio one limits odd values
    always_comb begin
        fine_bad = (link.fine_output_divider < FINE_MIN) ||
                   (link.fine_output_divider > FINE_MAX);
        if ((link.power_of_two_divider == '0) && link.fine_output_divider[0] &&
            (link.fine_output_divider > FINE_ODD_MAX)) begin
            fine_bad = 1'b1;
        end
    end

    // Settings register: plain binary fields, no conversion on the way in
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            power_of_two_select_o     <= '0;
            fine_output_divider_o     <= '0;
            feedback_ratio_integer_o  <= '0;
            feedback_ratio_fraction_o <= '0;
            tuning_gain_trim_o        <= '0;
        end else if (link.load) begin
            power_of_two_select_o     <= link.power_of_two_divider;
            fine_output_divider_o     <= link.fine_output_divider;
            feedback_ratio_integer_o  <= link.feedback_ratio[FB_W-1:FRAC_W];
            feedback_ratio_fraction_o <= link.feedback_ratio[FRAC_W-1:0];
            tuning_gain_trim_o        <= link.tuning_gain_trim;
        end
    end

    // Exponent decode; codes above the top one saturate at the largest ratio
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            power_of_two_ratio_o <= 6'h01;
        end else if (link.load) begin
            if (link.power_of_two_divider >= POW2_EXP_MAX) begin
                power_of_two_ratio_o <= POW2_RATIO_CAP;
            end else begin
                power_of_two_ratio_o <= 6'h01 << link.power_of_two_divider;
            end
        end
    end

    // Status; nothing here depends on speed grade, so a plan carries over unchanged
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            settings_loaded_o <= 1'b0;
            settings_valid_o  <= 1'b0;
            setting_error_o   <= 1'b0;
        end else begin
            settings_loaded_o <= link.load;
            if (link.load) begin
                settings_valid_o <= ~fine_bad;
                setting_error_o  <= fine_bad;
            end
        end
    end

endmodule

`default_nettype wire

// ### hw/divider_plan_calculator.sv
// Host end: AHB-Lite register slave plus a sequential divider planner.
// Assumes a single AHB-Lite master issuing single word transfers, hready = hreadyout.
`timescale 1ns/1ps
`default_nettype none

module divider_plan_calculator
    import divider_plan_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         hsel_i,
    input  wire logic [31:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic [31:0]       hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    divider_plan_if.host      link
);

    plan_state_t         state_ff;
    plan_state_t         nxt_state;
    logic                pend_ff;
    logic                pend_write_ff;
    logic [7:0]          pend_addr_ff;
    logic [31:0]         fout_ff;
    logic                done_ff;
    logic                error_ff;
    logic [TOTAL_W-1:0]  total_ff;
    logic [EXP_W-1:0]    exp_ff;
    logic [INT_W-1:0]    fine_ff;
    logic [DEN_W-1:0]    fvco_ff;
    logic [FB_W-1:0]     feedback_ff;
    logic [TRIM_W-1:0]   pre_ff;
    logic [TRIM_W-1:0]   trim_ff;
    logic                load_ff;
    logic [DIV_W-1:0]    num_ff;
    logic [DEN_W-1:0]    den_ff;
    logic [DEN_W-1:0]    rem_ff;
    logic [6:0]          cnt_ff;
    logic                start_req;
    logic                div_busy;
    logic                div_start;
    logic [DIV_W-1:0]    div_num;
    logic [DEN_W-1:0]    div_den;
    logic [CALC_W-1:0]   fvco_calc;
    logic                fvco_ok;
    logic [TRIM_W-1:0]   pre_calc;
    logic [INT_W-1:0]    fine_calc;
    logic [DEN_W:0]      rem_shift;
    logic                take;
    logic [31:0]         rd_mux;

    assign start_req = pend_ff && pend_write_ff && (pend_addr_ff == REG_CONTROL) &&
                       hwdata_i[CTRL_START_BIT];
    assign div_busy  = (cnt_ff != '0);

    // Bus slave: one wait state so that read data leaves a flip-flop
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_ff       <= 1'b0;
            pend_write_ff <= 1'b0;
            pend_addr_ff  <= '0;
            hreadyout_o   <= 1'b1;
            hresp_o       <= 1'b0;
        end else if (hsel_i && htrans_i[1] && hready_i) begin
            pend_ff       <= 1'b1;
            pend_write_ff <= hwrite_i;
            pend_addr_ff  <= {haddr_i[7:2], 2'b00};
            hreadyout_o   <= 1'b0;
        end else if (pend_ff) begin
            pend_ff     <= 1'b0;
            hreadyout_o <= 1'b1;
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rd_mux = '0;
        case (pend_addr_ff)
            REG_REQ_FREQ: rd_mux = fout_ff;
            REG_STATUS: begin
                rd_mux[STAT_BUSY_BIT]  = (state_ff != S_IDLE);
                rd_mux[STAT_DONE_BIT]  = done_ff;
                rd_mux[STAT_ERROR_BIT] = error_ff;
            end
            REG_DIVIDERS: begin
                rd_mux[EXP_W-1:0]                     = exp_ff;
                rd_mux[DIVS_FINE_LSB+INT_W-1:DIVS_FINE_LSB] = fine_ff;
            end
            REG_FB_LOW:  rd_mux = feedback_ff[FRAC_W-1:0];
            REG_FB_HIGH: rd_mux[INT_W-1:0] = feedback_ff[FB_W-1:FRAC_W];
            REG_TRIM: begin
                rd_mux[TRIM_W-1:0]                      = trim_ff;
                rd_mux[TRIM_PRE_LSB+TRIM_W-1:TRIM_PRE_LSB] = pre_ff;
            end
            default: rd_mux = '0;
        endcase
    end

    // Read data and requested frequency; frequency writes while busy are dropped
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hrdata_o <= '0;
            fout_ff  <= '0;
        end else if (pend_ff) begin
            hrdata_o <= pend_write_ff ? 32'h0 : rd_mux;
            if (pend_write_ff && (pend_addr_ff == REG_REQ_FREQ) && (state_ff == S_IDLE)) begin
                fout_ff <= hwdata_i;
            end
        end
    end

    // Planner arithmetic seen by the state machine
    always_comb begin
        fvco_calc = (CALC_W'(fout_ff) * CALC_W'(fine_ff)) << exp_ff;
        fvco_ok   = (fvco_calc >= FVCO_MIN_HZ) && (fvco_calc <= FVCO_MAX_HZ);
        if (feedback_ff[FB_W-1:FRAC_W] < PRE_LIMIT_18) begin
            pre_calc = PRE_16;
        end else if (feedback_ff[FB_W-1:FRAC_W] < PRE_LIMIT_20) begin
            pre_calc = PRE_18;
        end else if (feedback_ff[FB_W-1:FRAC_W] < PRE_LIMIT_22) begin
            pre_calc = PRE_20;
        end else begin
            pre_calc = PRE_22;
        end
        fine_calc = total_ff[INT_W-1:0];
        if ((exp_ff == '0) && fine_calc[0] && (fine_calc > FINE_ODD_MAX)) begin
            fine_calc = fine_calc + 11'h001;
        end
        if (fine_calc < FINE_MIN) begin
            fine_calc = FINE_MIN;
        end
    end

    // Next state and divider launches
    always_comb begin
        nxt_state = state_ff;
        div_start = 1'b0;
        div_num   = '0;
        div_den   = '0;
        case (state_ff)
            S_IDLE: begin
                if (start_req) begin
                    if (fout_ff == '0) begin
                        nxt_state = S_ERROR;
                    end else begin
                        // Ceiling of minimum oscillator over output: lowest total divide
                        div_start = 1'b1;
                        div_num   = DIV_W'(FVCO_MIN_HZ) + DIV_W'(fout_ff) - DIV_W'(1);
                        div_den   = DEN_W'(fout_ff);
                        nxt_state = S_DIV_TOTAL;
                    end
                end
            end
            S_DIV_TOTAL: begin
                if (!div_busy) begin
                    nxt_state = (num_ff[DIV_W-1:TOTAL_W-1] != '0) ? S_ERROR : S_PICK;
                end
            end
            S_PICK: begin
                if (total_ff > TOTAL_W'(FINE_MAX)) begin
                    nxt_state = (exp_ff == POW2_EXP_MAX) ? S_ERROR : S_PICK;
                end else begin
                    nxt_state = S_CHECK;
                end
            end
            S_CHECK: begin
                if (fvco_ok) begin
                    // Truncating quotient gives the fraction field unrounded
                    div_start = 1'b1;
                    div_num   = DIV_W'(fvco_calc) << FRAC_W;
                    div_den   = FOSC_HZ;
                    nxt_state = S_DIV_FB;
                end else begin
                    nxt_state = S_ERROR;
                end
            end
            S_DIV_FB: begin
                if (!div_busy) begin
                    nxt_state = S_PRE;
                end
            end
            S_PRE: begin
                // Adding half the divisor turns the truncating divide into rounding
                div_start = 1'b1;
                div_num   = DIV_W'(GAIN_NUM) * DIV_W'(pre_calc) + DIV_W'(fvco_ff >> 1);
                div_den   = fvco_ff;
                nxt_state = S_DIV_GAIN;
            end
            S_DIV_GAIN: begin
                if (!div_busy) begin
                    nxt_state = S_SEND;
                end
            end
            S_SEND:  nxt_state = S_IDLE;
            S_ERROR: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Shared restoring divider: quotient bits shift into num_ff, one per cycle
    assign rem_shift = {rem_ff, num_ff[DIV_W-1]};
    assign take      = (rem_shift >= {1'b0, den_ff});

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            num_ff <= '0;
            den_ff <= '0;
            rem_ff <= '0;
            cnt_ff <= '0;
        end else if (div_start) begin
            num_ff <= div_num;
            den_ff <= div_den;
            rem_ff <= '0;
            cnt_ff <= DIV_STEPS;
        end else if (div_busy) begin
            rem_ff <= take ? DEN_W'(rem_shift - {1'b0, den_ff}) : DEN_W'(rem_shift);
            num_ff <= {num_ff[DIV_W-2:0], take};
            cnt_ff <= cnt_ff - 7'h01;
        end
    end

    // Plan results, filled in stage by stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            total_ff    <= '0;
            exp_ff      <= '0;
            fine_ff     <= '0;
            fvco_ff     <= '0;
            feedback_ff <= '0;
            pre_ff      <= '0;
            trim_ff     <= '0;
        end else begin
            case (state_ff)
                S_DIV_TOTAL: begin
                    if (!div_busy) begin
                        total_ff <= num_ff[TOTAL_W-1:0];
                        exp_ff   <= '0;
                    end
                end
                S_PICK: begin
                    if (total_ff > TOTAL_W'(FINE_MAX)) begin
                        if (exp_ff != POW2_EXP_MAX) begin
                            // Halve with ceiling so the product never drops below minimum
                            total_ff <= TOTAL_W'((total_ff + TOTAL_W'(1)) >> 1);
                            exp_ff   <= exp_ff + 3'h1;
                        end
                    end else begin
                        fine_ff <= fine_calc;
                    end
                end
                S_CHECK:  fvco_ff <= fvco_calc[DEN_W-1:0];
                S_DIV_FB: begin
                    if (!div_busy) begin
                        feedback_ff <= num_ff[FB_W-1:0];
                    end
                end
                S_PRE: pre_ff <= pre_calc;
                S_DIV_GAIN: begin
                    if (!div_busy) begin
                        trim_ff <= (num_ff[DIV_W-1:TRIM_W] != '0) ? 8'hff : num_ff[TRIM_W-1:0];
                    end
                end
                default: total_ff <= total_ff;
            endcase
        end
    end

    // Completion flags; cleared only by a start, which is taken only when idle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            done_ff  <= 1'b0;
            error_ff <= 1'b0;
            load_ff  <= 1'b0;
        end else begin
            load_ff <= (state_ff == S_SEND);
            if (start_req && (state_ff == S_IDLE)) begin
                done_ff  <= 1'b0;
                error_ff <= 1'b0;
            end else if (state_ff == S_SEND) begin
                done_ff <= 1'b1;
            end else if (state_ff == S_ERROR) begin
                error_ff <= 1'b1;
            end
        end
    end

    // Link fields stand from flip-flops; only load marks them fresh
    assign link.load                 = load_ff;
    assign link.power_of_two_divider = exp_ff;
    assign link.fine_output_divider  = fine_ff;
    assign link.feedback_ratio       = feedback_ff;
    assign link.tuning_gain_trim     = trim_ff;

endmodule

`default_nettype wire

// ### testbench/divider_plan_asserts.sv
// Assertions on the plan link, watched beside the interface.
// Assumes one clock and an active-high synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module divider_plan_asserts
    import divider_plan_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              load,
    input  wire logic [EXP_W-1:0]  power_of_two_divider,
    input  wire logic [INT_W-1:0]  fine_output_divider,
    input  wire logic [FB_W-1:0]   feedback_ratio,
    input  wire logic [TRIM_W-1:0] tuning_gain_trim
);
    logic [2:0]  ex;
    logic [10:0] fine;
    logic [10:0] fbi;
    logic [7:0]  trim;

    // Integer part of the ratio stands in for the oscillator rate
    assign ex   = power_of_two_divider;
    assign fine = fine_output_divider;
    assign fbi  = feedback_ratio[FB_W-1:FRAC_W];
    assign trim = tuning_gain_trim;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Fields wander mid-calculation, so only a load qualifies them
    load_pulse_a: assert property (load |=> !load)
        else $error("load held past one cycle");
    exp_range_a: assert property (load |-> ex <= 3'h5)
        else $error("exponent above five");
    fine_range_a: assert property (load |-> fine inside {[11'h005:11'h7fe]})
        else $error("fine ratio out of range");
    odd_fine_a: assert property (load && ex == 3'h0 && fine > 11'h021 |-> !fine[0])
        else $error("odd fine ratio above 33");
    pow2_need_a: assert property (load && ex != 3'h0 |-> fine > 11'h3ff)
        else $error("coarse divide used needlessly");
    vco_window_a: assert property (load |-> fbi inside {[11'h046:11'h055]})
        else $error("oscillator rate outside window");
    // Trim bands follow from the predivider and the rate span of each band
    trim_low_a: assert property (load && fbi < 11'h048
        |-> trim inside {[8'h77:8'h79]})
        else $error("trim wrong for lowest band");
    trim_mid_a: assert property (load && fbi inside {[11'h048:11'h04e]}
        |-> trim inside {[8'h7a:8'h86]})
        else $error("trim wrong for middle band");
    trim_high_a: assert property (load && fbi > 11'h04e
        |-> trim inside {[8'h7d:8'h88]})
        else $error("trim wrong for upper band");
endmodule
`default_nettype wire

// ### testbench/divider_plan_calculator_tb.sv
// Bench for the plan calculator feeding the oscillator register end.
// Assumes one 125 MHz clock and a one-wait-state bus slave.
`timescale 1ns/1ps
`default_nettype none
module divider_plan_calculator_tb;
    import divider_plan_pkg::*;

    typedef struct packed {
        logic        ok;
        logic [2:0]  ex;
        logic [10:0] fine;
        logic [42:0] fb;
        logic [7:0]  pre;
        logic [7:0]  trim;
    } plan_t;

    logic        clk_i;
    logic        reset_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  dev_sel;
    logic [5:0]  dev_ratio;
    logic [10:0] dev_fine;
    logic [10:0] dev_int;
    logic [31:0] dev_frac;
    logic [7:0]  dev_trim;
    logic        dev_loaded;
    logic        dev_valid;
    logic        dev_err;
    logic [31:0] d;
    int          failures = 0;
    int          cmp_count = 0;
    int          loads = 0;
    // Edges of the divider limits, the worked example and refusals
    logic [31:0] corners [9] = '{32'h957d0b0, 32'h0, 32'h30d40, 32'h1381c918, 32'hf4240,
                                 32'h186a0, 32'hee6b2800, 32'h508b81, 32'h508b80};

    divider_plan_if lnk ();

    divider_plan_calculator divider_plan_calculator_i (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .link(lnk));

    oscillator_divider_regs oscillator_divider_regs_i (
        .clk_i(clk_i), .reset_i(reset_i), .link(lnk), .power_of_two_select_o(dev_sel),
        .power_of_two_ratio_o(dev_ratio), .fine_output_divider_o(dev_fine),
        .feedback_ratio_integer_o(dev_int), .feedback_ratio_fraction_o(dev_frac),
        .tuning_gain_trim_o(dev_trim), .settings_loaded_o(dev_loaded),
        .settings_valid_o(dev_valid), .setting_error_o(dev_err));

    divider_plan_asserts divider_plan_asserts_i (
        .clk_i(clk_i), .reset_i(reset_i), .load(lnk.load),
        .power_of_two_divider(lnk.power_of_two_divider),
        .fine_output_divider(lnk.fine_output_divider),
        .feedback_ratio(lnk.feedback_ratio), .tuning_gain_trim(lnk.tuning_gain_trim));

    // Free-running 8 ns clock
    always #4 clk_i = ~clk_i;

    // Count device load pulses so a missing or extra load shows up
    always @(posedge clk_i) if (dev_loaded === 1'b1) loads <= loads + 1;

    // Expected plan; wide math avoids overflow in the ratio shift
    function automatic plan_t calc(input logic [31:0] f);
        plan_t       p;
        logic [79:0] tot;
        logic [79:0] fv;
        logic [79:0] t;
        p = '0;
        if (f == 32'h0) return p;
        tot = (FVCO_MIN_HZ + f - 1) / f;
        if (tot > 80'hffff) return p;
        while (tot > 80'd2046) begin
            if (p.ex == 3'h5) return p;
            tot = (tot + 1) / 2;
            p.ex = p.ex + 3'h1;
        end
        if (p.ex == 3'h0 && tot > 80'd33 && tot[0]) tot = tot + 1;
        if (tot < 80'd5) tot = 80'd5;
        p.fine = tot[10:0];
        fv = (f * tot) << p.ex;
        if (fv > FVCO_MAX_HZ) return p;
        t = (fv << 32) / FOSC_HZ;
        p.fb = t[42:0];
        p.pre = t[42:32] < 11'h048 ? 8'h10 : t[42:32] < 11'h04f ? 8'h12 :
                t[42:32] < 11'h056 ? 8'h14 : 8'h16;
        t = (GAIN_NUM * p.pre * 2 + fv) / (fv * 2);
        p.trim = t > 80'hff ? 8'hff : t[7:0];
        p.ok = 1'b1;
        return p;
    endfunction

    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Sample ready mid-cycle, so the value seen is the one the next edge samples
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            failures++;
            end_of_test();
        end
        @(posedge clk_i);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    // One plan: start; a valid plan also gets a refused write while busy and full compares, a refused one only status and loads
    task automatic run_plan(input logic [31:0] f);
        plan_t p;
        int    l0;
        int    n;
        p = calc(f);
        l0 = loads;
        bus(1'b1, REG_REQ_FREQ, f, d);
        bus(1'b1, REG_CONTROL, 32'h1, d);
        if (p.ok) bus(1'b1, REG_REQ_FREQ, ~f, d);
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0, d);
            n++;
        end while (d[0] !== 1'b0 && n < 200);
        // A plan that never finishes is a hang, not a slow answer
        if (d[0] !== 1'b0) begin
            failures++;
            end_of_test();
        end
        // Let the device's load pulse reach the counter before it is compared
        @(negedge clk_i);
        check("status", d[2:0], {!p.ok, p.ok, 1'b0});
        check("loads", 80'(loads - l0), 80'(p.ok));
        if (p.ok) begin
            bus(1'b0, REG_REQ_FREQ, 32'h0, d);
            check("req_kept", d, f);
            bus(1'b0, REG_DIVIDERS, 32'h0, d);
            check("dividers", {d[26:16], d[2:0]}, {p.fine, p.ex});
            bus(1'b0, REG_FB_LOW, 32'h0, d);
            check("fb_low", d, p.fb[31:0]);
            bus(1'b0, REG_FB_HIGH, 32'h0, d);
            check("fb_high", d[10:0], p.fb[42:32]);
            bus(1'b0, REG_TRIM, 32'h0, d);
            check("trim", d[15:0], {p.pre, p.trim});
            check("device", {dev_sel, dev_fine, dev_int, dev_frac, dev_trim, dev_valid, dev_err},
                  {p.ex, p.fine, p.fb, p.trim, 2'b10});
            check("ratio", dev_ratio, 6'h01 << p.ex);
        end
        $display("plan %0h ok %0b done", f, p.ok);
    endtask

    initial begin
        clk_i = 1'b0;
        reset_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        d = $urandom(31611);
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        check("reset", {hreadyout, hresp, dev_ratio, dev_fine, dev_trim, dev_valid, dev_loaded},
              {2'b10, 6'h01, 11'h0, 8'h0, 2'b00});
        @(posedge clk_i);
        reset_i <= 1'b0;
        bus(1'b1, REG_REQ_FREQ, 32'h1234_5678, d);
        bus(1'b1, 8'h1c, 32'hffff_ffff, d);
        bus(1'b0, REG_REQ_FREQ, 32'h0, d);
        check("req_freq", d, 32'h1234_5678);
        bus(1'b0, 8'h1c, 32'h0, d);
        check("unmapped", {hresp, d}, 33'h0);
        $display("register access done");
        // Known worked plan pins the bench's own arithmetic to fixed values
        check("worked_plan", calc(32'h957d0b0),
              {1'b1, 3'h0, 11'h046, 43'h047e756e62a, 8'h10, 8'h77});
        foreach (corners[i]) run_plan(corners[i]);
        repeat (12) run_plan($urandom_range(32'hb2d05e00, 32'h30d40));
        end_of_test();
    end
endmodule
`default_nettype wire
